// file: hdl/scrs_pkg.sv
// Timing constants and encodings for the serial channel reset sequencer.
package scrs_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int PLL_LOCK_NS = 1000;
	localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFFSET_CANCEL_NS = 2000;
	localparam int OFFSET_CANCEL_CYC = OFFSET_CANCEL_NS / CLK_PERIOD_NS;
	localparam int RECONF_BUSY_NS = 200;
	localparam int RECONF_BUSY_CYC = RECONF_BUSY_NS / CLK_PERIOD_NS;
	localparam int RX_PLL_LOCK_NS = 1000;
	localparam int RX_PLL_LOCK_CYC = (RX_PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_LOCK_NS = 500;
	localparam int DATA_LOCK_CYC = (DATA_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CNT_W = 8;

	typedef enum logic [1:0] {
		SCRS_MODE_AUTO = 2'h0,
		SCRS_MODE_MAN_REF = 2'h1,
		SCRS_MODE_MAN_DATA = 2'h2
	} scrs_mode_t;

	typedef enum logic [1:0] {
		SCRS_CDR_IDLE = 2'h0,
		SCRS_CDR_REF = 2'h1,
		SCRS_CDR_DATA = 2'h2
	} scrs_cdr_t;
endpackage : scrs_pkg

// file: hdl/scrs_lock_timer.sv
// Lock acquisition timer that raises done after a run of enabled cycles.
`timescale 1ns/1ps
`default_nettype none
module scrs_lock_timer
	import scrs_pkg::*;
#(
	parameter int COUNT = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic done
);
	localparam int W = $clog2(COUNT + 1);

	initial begin
		if (COUNT < 1) begin
			$error("Lock timer count must be at least one.");
		end
	end

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} scrs_tmr_t;

	scrs_tmr_t st_r;
	scrs_tmr_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!run) begin
			st_nxt.cnt = '0;
			st_nxt.done = 1'b0;
		end else if (st_r.cnt != W'(COUNT)) begin
			st_nxt.cnt = st_r.cnt + W'(1);
			st_nxt.done = (st_r.cnt + W'(1)) == W'(COUNT);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done = st_r.done;
endmodule : scrs_lock_timer
`default_nettype wire

// file: hdl/scrs_channel.sv
// Transceiver channel model that answers the user reset sequence.
`timescale 1ns/1ps
`default_nettype none
module scrs_channel
	import scrs_pkg::*;
#(
	parameter int PLL_CYC = PLL_LOCK_CYC,
	parameter int OFFSET_CYC = OFFSET_CANCEL_CYC,
	parameter int RECONF_CYC = RECONF_BUSY_CYC,
	parameter int RX_PLL_CYC = RX_PLL_LOCK_CYC,
	parameter int DATA_CYC = DATA_LOCK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic txPllReset,
	input wire logic txDigitalReset,
	input wire logic rxAnalogReset,
	input wire logic rxDigitalReset,
	input wire logic referenceLockModeReq,
	input wire logic dataLockModeReq,
	input wire logic reconfigAccess,
	input wire logic rxSignalPresent,
	output logic pllLocked,
	output logic busy,
	output logic rxPllLocked,
	output logic freqLocked,
	output logic cdrDataMode,
	output logic txReady,
	output logic rxReady
);
	// Refuse counts that the busy counter or the lock timers cannot hold.
	initial begin
		if (OFFSET_CYC < 1 || OFFSET_CYC >= 2 ** BUSY_CNT_W) begin
			$error("Offset cancellation count out of range.");
		end
		if (RECONF_CYC < 1 || RECONF_CYC >= 2 ** BUSY_CNT_W) begin
			$error("Reconfiguration busy count out of range.");
		end
		if (PLL_CYC < 1) begin
			$error("Transmit PLL lock count must be at least one.");
		end
		if (RX_PLL_CYC < 1) begin
			$error("Receive PLL lock count must be at least one.");
		end
		if (DATA_CYC < 1) begin
			$error("Data lock count must be at least one.");
		end
	end

	// Channel state outside the lock timers, registered once per clock.
	typedef struct packed {
		logic [BUSY_CNT_W-1:0] busyCnt;
		logic busy;
		scrs_cdr_t cdr;
		logic rxPllLocked;
		logic freqLocked;
		logic dataLocked;
		logic txReady;
		logic rxReady;
	} scrs_state_t;

	scrs_state_t st_r;
	scrs_state_t st_nxt;
	scrs_mode_t mode;
	logic pllDone;
	logic refDone;
	logic dataDone;

	// Each receive lock timer runs only while the recovery unit sits in its state.
	function automatic logic cdrTimerRun(scrs_cdr_t cur, scrs_cdr_t want,
		logic anaRst);
		return cur == want && !anaRst;
	endfunction : cdrTimerRun

	// Leaving data lock drops both data lock flags in the same cycle.
	function automatic scrs_state_t leaveDataMode(scrs_state_t s);
		scrs_state_t r;
		r = s;
		r.cdr = SCRS_CDR_REF;
		r.dataLocked = 1'b0;
		r.freqLocked = 1'b0;
		return r;
	endfunction : leaveDataMode

	// The transmit PLL counts its lock time only while out of reset.
	scrs_lock_timer #(.COUNT(PLL_CYC)) pllTimer (
		.clk(clk),
		.rst(rst),
		.run(!txPllReset),
		.done(pllDone)
	);

	scrs_lock_timer #(.COUNT(RX_PLL_CYC)) refTimer (
		.clk(clk),
		.rst(rst),
		.run(cdrTimerRun(st_r.cdr, SCRS_CDR_REF, rxAnalogReset)),
		.done(refDone)
	);

	scrs_lock_timer #(.COUNT(DATA_CYC)) dataTimer (
		.clk(clk),
		.rst(rst),
		.run(cdrTimerRun(st_r.cdr, SCRS_CDR_DATA, rxAnalogReset)),
		.done(dataDone)
	);

	// The data request wins over the reference request.
	always_comb begin
		if (dataLockModeReq) begin
			mode = SCRS_MODE_MAN_DATA;
		end else if (referenceLockModeReq) begin
			mode = SCRS_MODE_MAN_REF;
		end else begin
			mode = SCRS_MODE_AUTO;
		end
	end

	always_comb begin
		st_nxt = st_r;
		// Busy runs out its count, then only a reconfiguration access restarts it.
		if (st_r.busyCnt != '0) begin
			st_nxt.busyCnt = st_r.busyCnt - BUSY_CNT_W'(1);
			st_nxt.busy = st_r.busyCnt != BUSY_CNT_W'(1);
		// An access that lands while busy is counting is dropped, not queued.
		end else if (reconfigAccess) begin
			st_nxt.busyCnt = BUSY_CNT_W'(RECONF_CYC);
			st_nxt.busy = 1'b1;
		end else begin
			st_nxt.busy = 1'b0;
		end
		// Analog reset drops every receive lock at once.
		if (rxAnalogReset) begin
			st_nxt.cdr = SCRS_CDR_IDLE;
			st_nxt.rxPllLocked = 1'b0;
			st_nxt.freqLocked = 1'b0;
			st_nxt.dataLocked = 1'b0;
		end else begin
			unique case (st_r.cdr)
				SCRS_CDR_IDLE: begin
					st_nxt.cdr = SCRS_CDR_REF;
				end
				SCRS_CDR_REF: begin
					st_nxt.rxPllLocked = refDone;
					st_nxt.freqLocked = 1'b0;
					st_nxt.dataLocked = 1'b0;
					// Automatic mode leaves reference lock once it is in and data is seen.
					if (mode == SCRS_MODE_MAN_DATA) begin
						st_nxt.cdr = SCRS_CDR_DATA;
					end else if (mode == SCRS_MODE_AUTO && refDone && rxSignalPresent) begin
						st_nxt.cdr = SCRS_CDR_DATA;
					end
				end
				SCRS_CDR_DATA: begin
					st_nxt.dataLocked = dataDone;
					// Frequency lock is reported only in automatic mode.
					st_nxt.freqLocked = mode == SCRS_MODE_AUTO && dataDone;
					if (mode == SCRS_MODE_MAN_REF) begin
						st_nxt = leaveDataMode(st_nxt);
					end else if (mode == SCRS_MODE_AUTO && !rxSignalPresent) begin
						st_nxt = leaveDataMode(st_nxt);
					end
				end
				default: begin
					st_nxt.cdr = SCRS_CDR_IDLE;
				end
			endcase
		end
		// Ready follows the own digital reset of each direction.
		st_nxt.txReady = !txDigitalReset && pllDone;
		st_nxt.rxReady = !rxDigitalReset && st_nxt.dataLocked;
	end

	// Reset starts the offset cancellation run of busy.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.busyCnt <= BUSY_CNT_W'(OFFSET_CYC);
			st_r.busy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from flip-flops of the state or the timers, except cdrDataMode, which is decoded from the registered cdr state.
	assign pllLocked = pllDone;
	assign busy = st_r.busy;
	assign rxPllLocked = st_r.rxPllLocked;
	assign freqLocked = st_r.freqLocked;
	assign cdrDataMode = st_r.cdr == SCRS_CDR_DATA;
	assign txReady = st_r.txReady;
	assign rxReady = st_r.rxReady;
endmodule : scrs_channel
`default_nettype wire

// file: tb/scrs_channel_sva.sv
// Assertions on the channel model ports.
`timescale 1ns/1ps
`default_nettype none
module scrs_channel_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic txPllReset,
	input wire logic txDigitalReset,
	input wire logic rxAnalogReset,
	input wire logic referenceLockModeReq,
	input wire logic dataLockModeReq,
	input wire logic reconfigAccess,
	input wire logic pllLocked,
	input wire logic busy,
	input wire logic rxPllLocked,
	input wire logic freqLocked,
	input wire logic cdrDataMode,
	input wire logic txReady
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_pll_clear: assert property (txPllReset |=> !pllLocked)
		else $error("pll lock in reset");
	chk_pll_cause: assert property ($rose(pllLocked) |-> !$past(txPllReset))
		else $error("pll lock early");
	chk_busy_cause: assert property ($rose(busy) |-> $past(reconfigAccess))
		else $error("busy without access");
	chk_busy_end: assert property ($rose(busy) |-> ##[1:8] !busy)
		else $error("busy too long");
	chk_ana_clear: assert property (rxAnalogReset |=> !rxPllLocked && !freqLocked)
		else $error("rx lock in reset");
	chk_data_mode: assert property (dataLockModeReq && !rxAnalogReset
		&& $past(!rxAnalogReset) |=> cdrDataMode)
		else $error("no data mode");
	chk_ref_mode: assert property (referenceLockModeReq && !dataLockModeReq
		|=> !cdrDataMode)
		else $error("data mode on ref");
	chk_tx_ready: assert property (!$past(rst)
		|-> txReady == $past(pllLocked && !txDigitalReset))
		else $error("txReady wrong");
endmodule : scrs_channel_sva
bind scrs_channel scrs_channel_sva chk (.clk(clk), .rst(rst),
	.txPllReset(txPllReset), .txDigitalReset(txDigitalReset),
	.rxAnalogReset(rxAnalogReset), .reconfigAccess(reconfigAccess),
	.referenceLockModeReq(referenceLockModeReq),
	.dataLockModeReq(dataLockModeReq), .pllLocked(pllLocked), .busy(busy),
	.rxPllLocked(rxPllLocked), .freqLocked(freqLocked),
	.cdrDataMode(cdrDataMode), .txReady(txReady));
`default_nettype wire

// file: tb/scrs_ctrl_model.sv
// Behavioural user reset controller for one channel.
`timescale 1ns/1ps
`default_nettype none
module scrs_ctrl_model #(
	parameter int WAIT = 6
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic manual,
	input wire logic pllLocked,
	input wire logic busy,
	input wire logic freqLocked,
	output logic txPllReset,
	output logic txDigitalReset,
	output logic rxAnalogReset,
	output logic rxDigitalReset,
	output logic referenceLockModeReq,
	output logic dataLockModeReq
);
	int n = 0;
	int st = 0;
	task hold;
		{txPllReset, txDigitalReset, rxAnalogReset, rxDigitalReset,
			referenceLockModeReq, dataLockModeReq} = {4'hF, manual, 1'b0};
	endtask : hold
	initial hold;
	always @(posedge clk) begin
		#1;
		n = n + 1;
		if (rst) begin
			hold;
			st = 0;
			n = 0;
		end else if (st > 2 && !manual && !freqLocked) begin
			rxDigitalReset = 1'b1;
			st = 3;
			n = 0;
		end else case (st)
			0: if (n > 20) begin
				txPllReset = 1'b0;
				st = 1;
			end
			1: if (pllLocked) begin
				txDigitalReset = 1'b0;
				st = 2;
				n = 0;
			end
			2: if (busy) n = 0;
			else if (n == 2) begin
				rxAnalogReset = 1'b0;
				st = 3;
				n = 0;
			end
			3: if (n == WAIT) begin
				referenceLockModeReq = 1'b0;
				dataLockModeReq = manual;
				st = 4;
				n = 0;
			end
			4: if (n == WAIT) begin
				rxDigitalReset = 1'b0;
				st = 5;
			end
			default: ;
		endcase
	end
endmodule : scrs_ctrl_model
`default_nettype wire

// file: tb/test_scrs_channel.sv
// Self-checking bench for the channel model.
`timescale 1ns/1ps
`default_nettype none
module test_scrs_channel;
	logic clk = 0, rst = 1, man = 1, sig = 0, acc = 0;
	logic tpr, tdr, rar, rdr, rrq, drq, pl, bz, rpl, fl, cdm, txr, rxr;
	int bad_count = 0, check_count = 0, cyc = 0;
	initial forever #25 clk = ~clk;
	scrs_channel #(.PLL_CYC(4), .OFFSET_CYC(5), .RECONF_CYC(3),
		.RX_PLL_CYC(4), .DATA_CYC(3)) uut (.clk(clk), .rst(rst),
		.txPllReset(tpr), .txDigitalReset(tdr), .rxAnalogReset(rar),
		.rxDigitalReset(rdr), .referenceLockModeReq(rrq),
		.dataLockModeReq(drq), .reconfigAccess(acc), .rxSignalPresent(sig),
		.pllLocked(pl), .busy(bz), .rxPllLocked(rpl), .freqLocked(fl),
		.cdrDataMode(cdm), .txReady(txr), .rxReady(rxr));
	scrs_ctrl_model ctl (.clk(clk), .rst(rst), .manual(man),
		.pllLocked(pl), .busy(bz), .freqLocked(fl), .txPllReset(tpr),
		.txDigitalReset(tdr), .rxAnalogReset(rar), .rxDigitalReset(rdr),
		.referenceLockModeReq(rrq), .dataLockModeReq(drq));
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task check(input string s, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %b got %b", s, e, g);
		end
	endtask : check
	task print_verdict;
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task boot(input logic m);
		rst = 1;
		man = m;
		tick(12);
		rst = 0;
		tick(1);
		check("busy", 1'b1, bz);
	endtask : boot
	task wait_rx;
		for (int k = 0; k < 300 && rxr !== 1'b1; k++) tick(1);
	endtask : wait_rx
	task t_manual;
		boot(1);
		wait_rx;
		check("rxReady", 1'b1, rxr);
		check("cdrDataMode", 1'b1, cdm);
		check("txReady", 1'b1, txr);
		check("pllLocked", 1'b1, pl);
		check("rxPllLocked", 1'b1, rpl);
		acc = 1;
		tick(1);
		acc = 0;
		check("busy", 1'b1, bz);
		tick(4);
		check("busy", 1'b0, bz);
	endtask : t_manual
	task t_auto;
		sig = 1;
		boot(0);
		wait_rx;
		check("freqLocked", 1'b1, fl);
		sig = 0;
		tick(2);
		check("freqLocked", 1'b0, fl);
		check("rxReady", 1'b0, rxr);
		sig = 1;
		wait_rx;
		check("rxReady", 1'b1, rxr);
	endtask : t_auto
	initial begin
		t_manual;
		t_auto;
		print_verdict;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict;
		end
	end
endmodule : test_scrs_channel
`default_nettype wire
